// [bench/signed_compare_branch_unit_test.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
  $display("Error %0t: got %h want %h", $time, (a), (b)); end end

module signed_compare_branch_unit_test;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic                i_core_clk;
  logic                i_resetn;
  scbu_pkg::scbu_req_t i_req;
  logic                i_slot_done;
  logic                o_ready;
  scbu_pkg::scbu_res_t o_res;
  logic                o_irq_hold;
  int                  err_total;
  int                  checked;
  integer              seed;
  int                  cyc;
  scbu_pkg::scbu_res_t exp_q[$];
  int                  cyc_q[$];
  scbu_pkg::scbu_res_t exp_r;
  int                  exp_c;
  logic [31:0]         vals[5];
  localparam int       SLOW_MISS = 9;
  scbu_pkg::scbu_req_t i_req_slow;
  logic                o_ready_slow;
  scbu_pkg::scbu_res_t o_res_slow;
  logic                o_irq_hold_slow;
  int                  wait_n;

  scbu_top #(
    .AREA_OPTIMISE_PARAM (0),
    .P_BPRED             (1'b1),
    .P_MISS_CYCLES       (9)
  ) u_dut (
    .i_core_clk  (i_core_clk),
    .i_resetn    (i_resetn),
    .i_req       (i_req),
    .o_ready     (o_ready),
    .i_slot_done (i_slot_done),
    .o_res       (o_res),
    .o_irq_hold  (o_irq_hold)
  );

  // second copy in the slow area setting, only for the mispredict cost
  scbu_top #(
    .AREA_OPTIMISE_PARAM (2),
    .P_BPRED             (1'b1),
    .P_MISS_CYCLES       (SLOW_MISS)
  ) u_dut_slow (
    .i_core_clk  (i_core_clk),
    .i_resetn    (i_resetn),
    .i_req       (i_req_slow),
    .o_ready     (o_ready_slow),
    .i_slot_done (i_slot_done),
    .o_res       (o_res_slow),
    .o_irq_hold  (o_irq_hold_slow)
  );

  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end

  always @(posedge i_core_clk) cyc <= cyc + 1;

  // ----------------------------------------------------------------
  // result watcher
  // ----------------------------------------------------------------
  // sampled mid-cycle so the registered result has settled
  always @(negedge i_core_clk) begin
    if (o_res.valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        err_total++;
        $display("Error %0t: result with no request", $time);
      end else begin
        exp_r = exp_q.pop_front();
        exp_c = cyc_q.pop_front();
        `CHK(o_res, exp_r)
        `CHK(cyc, exp_c)
      end
    end
  end

  task automatic report_and_stop();
    if (err_total == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  function automatic logic hit(logic [3:0] c, logic [31:0] v);
    case (c)
      4'h2:    return $signed(v) < 0;
      4'h3:    return $signed(v) <= 0;
      default: return $signed(v) > 0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // one branch, with its expected result and timing
  // ----------------------------------------------------------------
  task automatic issue(input logic imm, input logic [3:0] cnd,
                       input logic d, input logic [31:0] val,
                       input logic pred);
    scbu_pkg::scbu_req_t r;
    scbu_pkg::scbu_res_t e;
    logic [31:0]         off;
    int                  lat;
    int                  n;
    r              = '0;
    r.valid        = 1'b1;
    r.instr        = {imm ? scbu_pkg::OPC_IMM : scbu_pkg::OPC_REG, d, cnd,
                      5'h03, 16'($random(seed))};
    r.pc           = 32'($random(seed)) & 32'hffff_fffc;
    r.cmp_val      = val;
    r.off_val      = 32'($random(seed));
    r.prefix_valid = imm & 1'($random(seed));
    r.prefix_hi    = 16'($random(seed));
    r.pred_taken   = pred;
    e         = '0;
    e.valid   = 1'b1;
    e.taken   = hit(cnd, val);
    e.delay   = d;
    e.flush   = e.taken && !d;
    e.pc      = r.pc;
    off       = !imm ? r.off_val :
                r.prefix_valid ? {r.prefix_hi, r.instr[15:0]} :
                {{16{r.instr[15]}}, r.instr[15:0]};
    e.next_pc = e.taken ? r.pc + off : r.pc + scbu_pkg::PC_STEP;
    lat = imm ? ((pred == e.taken) ? 1 : 3) : (!e.taken ? 1 : d ? 2 : 3);
    @(posedge i_core_clk);
    i_req <= r;
    #1;
    `CHK(o_irq_hold, d)
    @(posedge i_core_clk);
    i_req <= '0;
    #1;
    exp_q.push_back(e);
    cyc_q.push_back(cyc);
    `CHK(o_irq_hold, d)
    n = 0;
    while (o_ready !== 1'b1 && n < 20) begin
      @(posedge i_core_clk);
      #1;
      n++;
    end
    `CHK(n, lat - 1)
    if (n == 20) report_and_stop();
    if (d) begin
      `CHK(o_irq_hold, 1'b1)
      @(posedge i_core_clk);
      i_slot_done <= 1'b1;
      @(posedge i_core_clk);
      i_slot_done <= 1'b0;
      #1;
      `CHK(o_irq_hold, 1'b0)
    end
  endtask

  // a word outside this unit must give no result and no hold
  task automatic refuse(input logic [31:0] instr);
    @(posedge i_core_clk);
    i_req <= '{valid: 1'b1, instr: instr, default: '0};
    @(posedge i_core_clk);
    i_req <= '0;
    #1;
    `CHK(o_ready, 1'b1)
    `CHK(o_irq_hold, 1'b0)
    repeat (3) @(posedge i_core_clk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    seed        = 62;
    err_total   = 0;
    checked     = 0;
    cyc         = 0;
    vals        = '{32'hffff_ffff, 32'h0000_0000, 32'h0000_0001,
                    32'h8000_0000, 32'h7fff_ffff};
    i_resetn    = 1'b0;
    i_req       = '0;
    i_slot_done = 1'b0;
    i_req_slow  = '0;
    repeat (10) @(posedge i_core_clk);
    #1;
    `CHK(o_ready, 1'b1)
    `CHK(o_res, '0)
    `CHK(o_irq_hold, 1'b0)
    @(posedge i_core_clk);
    i_resetn <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    #1;
    // sign boundaries first, then random operands
    for (int f = 0; f < 2; f++) begin
      for (int c = 2; c < 5; c++) begin
        for (int k = 0; k < 8; k++) begin
          issue(f[0], 4'(c), 1'($random(seed)),
                (k < 5) ? vals[k] : 32'($random(seed)),
                1'($random(seed)));
        end
      end
    end
    refuse({scbu_pkg::OPC_REG, 1'b1, 4'h0, 21'h0});
    refuse({6'h26, 1'b1, 4'h2, 21'h0});
    // slow setting: taken immediate branch predicted not taken
    @(posedge i_core_clk);
    i_req_slow <= '{valid: 1'b1, cmp_val: 32'h0000_0001,
                    instr: {scbu_pkg::OPC_IMM, 1'b0,
                            scbu_pkg::SCBU_CND_GT, 21'h0},
                    default: '0};
    @(posedge i_core_clk);
    i_req_slow <= '0;
    #1;
    `CHK(o_res_slow.taken, 1'b1)
    `CHK(o_irq_hold_slow, 1'b0)
    wait_n = 0;
    while (o_ready_slow !== 1'b1 && wait_n < 20) begin
      @(posedge i_core_clk);
      #1;
      wait_n++;
    end
    `CHK(wait_n, SLOW_MISS - 1)
    repeat (3) @(posedge i_core_clk);
    `CHK(exp_q.size(), 0)
    report_and_stop();
  end

  // hang guard
  initial begin
    repeat (100000) @(posedge i_core_clk);
    err_total++;
    report_and_stop();
  end

endmodule

// [logic/scbu_cond.sv]
`timescale 1ns/1ps
module scbu_cond (
  // condition field and compared value
  input  wire logic [3:0]  i_cnd,
  input  wire logic [31:0] i_val,
  // verdict
  output logic             o_mine,
  output logic             o_hit
);

  logic neg;
  logic zero;

  assign neg  = i_val[scbu_pkg::SIGN_BIT];
  assign zero = (i_val == '0);

  always_comb begin
    o_mine = 1'b1;
    o_hit  = 1'b0;
    case (i_cnd)
      scbu_pkg::SCBU_CND_GT: o_hit = !neg && !zero;
      scbu_pkg::SCBU_CND_LE: o_hit = neg || zero;
      scbu_pkg::SCBU_CND_LT: o_hit = neg;
      default: begin
        o_mine = 1'b0;
      end
    endcase
  end

endmodule

// [logic/scbu_pkg.sv]
package scbu_pkg;

  // ----------------------------------------------------------------
  // instruction fields (bit 31 is the most significant bit)
  // ----------------------------------------------------------------
  localparam int unsigned OPC_HI    = 31;
  localparam int unsigned OPC_LO    = 26;
  localparam int unsigned DLY_BIT   = 25;
  localparam int unsigned CND_HI    = 24;
  localparam int unsigned CND_LO    = 21;
  localparam int unsigned IMM_HI    = 15;
  localparam int unsigned IMM_LO    = 0;
  localparam int unsigned IMM_W     = 16;
  localparam int unsigned XLEN      = 32;
  localparam int unsigned SIGN_BIT  = 31;

  localparam logic [5:0] OPC_REG    = 6'h27;
  localparam logic [5:0] OPC_IMM    = 6'h2f;

  // ----------------------------------------------------------------
  // condition codes handled here
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    SCBU_CND_LT = 4'h2,
    SCBU_CND_LE = 4'h3,
    SCBU_CND_GT = 4'h4
  } scbu_cnd_t;

  // ----------------------------------------------------------------
  // timing, in cycles of i_core_clk, and the fall-through pc step
  // ----------------------------------------------------------------
  localparam logic [3:0]  LAT_NOT_TAKEN = 4'h1;
  localparam logic [3:0]  LAT_TAKEN_DLY = 4'h2;
  localparam logic [3:0]  LAT_TAKEN_ND  = 4'h3;
  localparam logic [3:0]  LAT_MISS_FAST = 4'h3;
  localparam int unsigned LAT_MISS_MIN  = 7;
  localparam int unsigned LAT_MISS_MAX  = 9;
  localparam logic [31:0] PC_STEP       = 32'h0000_0004;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic [31:0] instr;
    logic [31:0] pc;
    logic [31:0] cmp_val;
    logic [31:0] off_val;
    logic        prefix_valid;
    logic [15:0] prefix_hi;
    logic        pred_taken;
  } scbu_req_t;

  typedef struct packed {
    logic        valid;
    logic        taken;
    logic        delay;
    logic        flush;
    logic [31:0] pc;
    logic [31:0] next_pc;
  } scbu_res_t;

endpackage

// [logic/scbu_top.sv]
`timescale 1ns/1ps
module scbu_top #(
  parameter int unsigned AREA_OPTIMISE_PARAM = 0,
  parameter bit          P_BPRED             = 1'b1,
  parameter int unsigned P_MISS_CYCLES       = 9
) (
  // clock and reset
  input  wire logic               i_core_clk,
  input  wire logic               i_resetn,
  // issue from decode
  input  wire scbu_pkg::scbu_req_t i_req,
  output logic                    o_ready,
  // retirement of the delay slot instruction
  input  wire logic               i_slot_done,
  // redirect to fetch
  output scbu_pkg::scbu_res_t     o_res,
  // to the interrupt and break sequencer
  output logic                    o_irq_hold
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (AREA_OPTIMISE_PARAM != 0 && AREA_OPTIMISE_PARAM != 2) begin : g_chk_a
    $error("area_optimise_param must be 0 or 2");
  end
  if (P_MISS_CYCLES < scbu_pkg::LAT_MISS_MIN ||
      P_MISS_CYCLES > scbu_pkg::LAT_MISS_MAX) begin : g_chk_m
    $error("P_MISS_CYCLES out of range");
  end

  localparam logic [3:0] LAT_MISS = (AREA_OPTIMISE_PARAM == 0) ?
                                    scbu_pkg::LAT_MISS_FAST :
                                    4'(P_MISS_CYCLES);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_r;
  logic rst_sync_r;
  logic rst_n;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  assign rst_n = rst_sync_r;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic [5:0]  opc;
  logic [3:0]  cnd;
  logic        dly;
  logic [15:0] imm;
  logic        is_reg;
  logic        is_imm;
  logic        mine;
  logic        hit;
  logic        acc;

  assign opc    = i_req.instr[scbu_pkg::OPC_HI:scbu_pkg::OPC_LO];
  assign cnd    = i_req.instr[scbu_pkg::CND_HI:scbu_pkg::CND_LO];
  assign dly    = i_req.instr[scbu_pkg::DLY_BIT];
  assign imm    = i_req.instr[scbu_pkg::IMM_HI:scbu_pkg::IMM_LO];
  assign is_reg = (opc == scbu_pkg::OPC_REG);
  assign is_imm = (opc == scbu_pkg::OPC_IMM);

  scbu_cond u_cond (
    .i_cnd  (cnd),
    .i_val  (i_req.cmp_val),
    .o_mine (mine),
    .o_hit  (hit)
  );

  // other branch kinds on the same opcodes belong to other units
  assign acc = i_req.valid && o_ready && mine && (is_reg || is_imm);

  // ----------------------------------------------------------------
  // target and fall-through
  // ----------------------------------------------------------------
  logic [31:0] imm_ext;
  logic [31:0] offset;
  logic [31:0] target;
  logic [31:0] seq_pc;

  always_comb begin
    if (i_req.prefix_valid) begin
      imm_ext = {i_req.prefix_hi, imm};
    end else begin
      imm_ext = {{(scbu_pkg::XLEN - scbu_pkg::IMM_W){imm[15]}}, imm};
    end
  end

  assign offset = is_reg ? i_req.off_val : imm_ext;
  assign target = i_req.pc + offset;
  assign seq_pc = i_req.pc + scbu_pkg::PC_STEP;

  // ----------------------------------------------------------------
  // cycle cost of the accepted branch
  // ----------------------------------------------------------------
  logic       miss;
  logic [3:0] lat;

  assign miss = P_BPRED && is_imm && (i_req.pred_taken != hit);

  always_comb begin
    lat = scbu_pkg::LAT_NOT_TAKEN;
    if (is_imm && P_BPRED) begin
      if (miss) begin
        lat = LAT_MISS;
      end
    end else if (hit) begin
      lat = dly ? scbu_pkg::LAT_TAKEN_DLY : scbu_pkg::LAT_TAKEN_ND;
    end
  end

  // ----------------------------------------------------------------
  // stall sequencer
  // ----------------------------------------------------------------
  typedef enum logic {
    ST_IDLE,
    ST_STALL
  } scbu_st_t;

  scbu_st_t   st_r;
  scbu_st_t   st_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;

  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    case (st_r)
      ST_IDLE: begin
        if (acc && lat != scbu_pkg::LAT_NOT_TAKEN) begin
          st_nxt  = ST_STALL;
          cnt_nxt = lat - 4'h1;
        end
      end
      ST_STALL: begin
        cnt_nxt = cnt_r - 4'h1;
        if (cnt_r == 4'h1) begin
          st_nxt = ST_IDLE;
        end
      end
      default: begin
        st_nxt  = ST_IDLE;
        cnt_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r  <= ST_IDLE;
      cnt_r <= '0;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign o_ready = (st_r == ST_IDLE);

  // ----------------------------------------------------------------
  // redirect result
  // ----------------------------------------------------------------
  scbu_pkg::scbu_res_t res_r;
  scbu_pkg::scbu_res_t res_nxt;

  always_comb begin
    res_nxt       = '0;
    res_nxt.valid = acc;
    if (acc) begin
      res_nxt.taken   = hit;
      res_nxt.delay   = dly;
      res_nxt.flush   = hit && !dly;
      res_nxt.pc      = i_req.pc;
      res_nxt.next_pc = hit ? target : seq_pc;
    end
  end

  // no register file or flag write port exists in this unit
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      res_r <= '0;
    end else begin
      res_r <= res_nxt;
    end
  end

  assign o_res = res_r;

  // ----------------------------------------------------------------
  // interrupt and break hold across the delay slot
  // ----------------------------------------------------------------
  logic hold_r;
  logic hold_nxt;

  // a new delayed branch cannot coincide with the slot retiring: the
  // slot holds no branch, so the clear and the set never collide
  always_comb begin
    hold_nxt = hold_r;
    if (acc && dly) begin
      hold_nxt = 1'b1;
    end else if (i_slot_done) begin
      hold_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_r <= 1'b0;
    end else begin
      hold_r <= hold_nxt;
    end
  end

  // covers the accept cycle too, so no interrupt slips in before it
  assign o_irq_hold = hold_r || (acc && dly);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!rst_n);

  logic cmp_neg;
  logic cmp_zero;
  assign cmp_neg  = i_req.cmp_val[scbu_pkg::SIGN_BIT];
  assign cmp_zero = (i_req.cmp_val == '0);

  sequence s_free_now;
    o_ready;
  endsequence
  sequence s_one_wait;
    !o_ready ##1 o_ready;
  endsequence
  sequence s_two_wait;
    !o_ready[*2] ##1 o_ready;
  endsequence

  a_gt_taken: assert property (
    acc && cnd == scbu_pkg::SCBU_CND_GT
    |=> o_res.taken == $past(!cmp_neg && !cmp_zero))
    else $error("greater-than decision wrong");

  a_le_taken: assert property (
    acc && cnd == scbu_pkg::SCBU_CND_LE
    |=> o_res.taken == $past(cmp_neg || cmp_zero))
    else $error("less-or-equal decision wrong");

  a_lt_taken: assert property (
    acc && cnd == scbu_pkg::SCBU_CND_LT
    |=> o_res.taken == $past(cmp_neg))
    else $error("less-than decision wrong");

  a_reg_target: assert property (
    acc && is_reg && hit
    |=> o_res.next_pc == $past(i_req.pc + i_req.off_val))
    else $error("register form target wrong");

  a_imm_sext: assert property (
    acc && is_imm && hit && !i_req.prefix_valid
    |=> o_res.next_pc == $past(i_req.pc + {{16{imm[15]}}, imm}))
    else $error("sign-extended target wrong");

  a_imm_prefix: assert property (
    acc && is_imm && hit && i_req.prefix_valid
    |=> o_res.next_pc == $past(i_req.pc + {i_req.prefix_hi, imm}))
    else $error("prefixed target wrong");

  a_seq_step: assert property (
    o_res.valid && !o_res.taken
    |-> o_res.next_pc == o_res.pc + scbu_pkg::PC_STEP)
    else $error("fall-through address wrong");

  a_slot_flush: assert property (
    o_res.valid |-> o_res.flush == (o_res.taken && !o_res.delay))
    else $error("squash of next instruction wrong");

  a_reg_nt_lat: assert property (
    acc && is_reg && !hit |=> s_free_now)
    else $error("not-taken branch stalled");

  a_reg_dly_lat: assert property (
    acc && is_reg && hit && dly |=> s_one_wait)
    else $error("taken delayed branch not two cycles");

  a_reg_nd_lat: assert property (
    acc && is_reg && hit && !dly |=> s_two_wait)
    else $error("taken plain branch not three cycles");

  a_pred_ok: assert property (
    acc && is_imm && P_BPRED && !miss |=> s_free_now)
    else $error("predicted branch stalled");

  a_miss_cost: assert property (
    acc && miss && AREA_OPTIMISE_PARAM == 0 |=> s_two_wait)
    else $error("misprediction cost not three cycles");

  a_miss_slow: assert property (
    acc && miss && AREA_OPTIMISE_PARAM == 2 |=> !o_ready[*6])
    else $error("misprediction cost below seven cycles");

  a_hold_keep: assert property (
    hold_r && !i_slot_done |=> o_irq_hold)
    else $error("interrupt hold dropped early");

endmodule
